// ### pulse_pattern_detector.sv
`timescale 1ns/1ps

// Function
// - detector runs only while enable bit set
// - sample pin, time high and low pulses
// - edge captures count then restarts counter
// - falling over high threshold sets flag 6
// - high flag also on saturation at 0xff
// - rising over low threshold sets flag 7
// - low flag also on saturation at 0xff
// - mask gates interrupt, flags still set
// - counts still load while interrupts masked
// - three-bit debounce field in bits 0-2
// - sample divider 2**field, resets to 111
// - control bits 3 and 7 read zero
module pulse_pattern_detector (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // pattern pin
    input  wire logic        pattern_input_pin,
    // interrupt
    output logic             irq
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0] high_pattern_count_r;
    logic [7:0] low_pattern_count_r;
    logic [7:0] pattern_detect_control_r;
    logic [7:0] system_control_bits_r;
    logic [7:0] interrupt_flags_r;
    logic [7:0] interrupt_mask_r;
    logic [7:0] count_r;
    logic [2:0] stable_r;
    logic       pin_meta_r;
    logic       pin_sync_r;
    logic       level_r;
    logic       sat_seen_r;
    logic       tick;
    logic       enabled;
    logic       wr_en;
    logic       access;
    logic       rise;
    logic       fall;
    logic       high_evt;
    logic       low_evt;
    logic       new_level;
    logic       at_max;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    assign access  = psel && penable;
    assign wr_en   = access && pwrite;
    assign enabled = system_control_bits_r[pattern_pkg::ENABLE_BIT];

    function automatic logic known(input logic [7:0] a);
        known = (a == pattern_pkg::ADDR_HIGH_COUNT) ||
                (a == pattern_pkg::ADDR_LOW_COUNT)  ||
                (a == pattern_pkg::ADDR_CONTROL)    ||
                (a == pattern_pkg::ADDR_SYSCTRL)    ||
                (a == pattern_pkg::ADDR_FLAGS)      ||
                (a == pattern_pkg::ADDR_MASK)       ||
                (a == pattern_pkg::ADDR_STATUS);
    endfunction

    // ------------------------------------------------------------
    // pin synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pin_meta_r <= 1'b0;
            pin_sync_r <= 1'b0;
        end else begin
            pin_meta_r <= pattern_input_pin;
            pin_sync_r <= pin_meta_r;
        end
    end

    sample_prescaler u_prescaler (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .run     (enabled),
        .rate    (pattern_detect_control_r[pattern_pkg::RATE_LSB +: 3]),
        .tick    (tick)
    );

    // ------------------------------------------------------------
    // debounce: accept a level after stable samples
    // ------------------------------------------------------------
    assign new_level = tick && (pin_sync_r != level_r) &&
        (stable_r >= pattern_detect_control_r[pattern_pkg::DEB_LSB +: 3]);
    assign rise = new_level && !level_r;
    assign fall = new_level && level_r;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            stable_r <= 3'h0;
            level_r  <= 1'b0;
        end else if (!enabled) begin
            stable_r <= 3'h0;
            level_r  <= pin_sync_r;
        end else if (tick) begin
            if (pin_sync_r == level_r) begin
                stable_r <= 3'h0;
            end else if (new_level) begin
                stable_r <= 3'h0;
                level_r  <= pin_sync_r;
            end else begin
                stable_r <= 3'(stable_r + 3'h1);
            end
        end
    end

    // ------------------------------------------------------------
    // pulse counter, saturating
    // ------------------------------------------------------------
    assign at_max = (count_r == pattern_pkg::COUNT_MAX);

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            count_r    <= 8'h00;
            sat_seen_r <= 1'b0;
        end else if (!enabled || new_level) begin
            count_r    <= 8'h00;
            sat_seen_r <= 1'b0;
        end else if (tick) begin
            if (!at_max) begin
                count_r <= 8'(count_r + 8'h01);
            end
            sat_seen_r <= at_max;
        end
    end

    // ------------------------------------------------------------
    // events: threshold on edge, or saturation while level held
    // ------------------------------------------------------------
    assign high_evt = enabled && (
        (fall && ((count_r > high_pattern_count_r) || sat_seen_r)) ||
        (tick && level_r && !new_level && at_max && !sat_seen_r));
    assign low_evt = enabled && (
        (rise && ((count_r > low_pattern_count_r) || sat_seen_r)) ||
        (tick && !level_r && !new_level && at_max && !sat_seen_r));

    // ------------------------------------------------------------
    // count registers: capture or software storage
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            high_pattern_count_r <= pattern_pkg::COUNT_RESET;
            low_pattern_count_r  <= pattern_pkg::COUNT_RESET;
        end else begin
            if (enabled && fall) begin
                high_pattern_count_r <= count_r;
            end else if (wr_en && paddr == pattern_pkg::ADDR_HIGH_COUNT) begin
                high_pattern_count_r <= pwdata[7:0];
            end
            if (enabled && rise) begin
                low_pattern_count_r <= count_r;
            end else if (wr_en && paddr == pattern_pkg::ADDR_LOW_COUNT) begin
                low_pattern_count_r <= pwdata[7:0];
            end
        end
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pattern_detect_control_r <= pattern_pkg::CONTROL_RESET;
            system_control_bits_r    <= 8'h00;
            interrupt_mask_r         <= 8'h00;
        end else if (wr_en) begin
            if (paddr == pattern_pkg::ADDR_CONTROL) begin
                pattern_detect_control_r <=
                    pwdata[7:0] & pattern_pkg::CONTROL_MASK;
            end
            if (paddr == pattern_pkg::ADDR_SYSCTRL) begin
                system_control_bits_r <= pwdata[7:0];
            end
            if (paddr == pattern_pkg::ADDR_MASK) begin
                interrupt_mask_r <= pwdata[7:0];
            end
        end
    end

    // ------------------------------------------------------------
    // sticky flags, write one to clear, set wins
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            interrupt_flags_r <= 8'h00;
        end else begin
            for (int i = 0; i < 8; i++) begin
                if ((i == pattern_pkg::HIGH_FLAG_BIT && high_evt) ||
                    (i == pattern_pkg::LOW_FLAG_BIT && low_evt)) begin
                    interrupt_flags_r[i] <= 1'b1;
                end else if (wr_en && paddr == pattern_pkg::ADDR_FLAGS &&
                             pwdata[i]) begin
                    interrupt_flags_r[i] <= 1'b0;
                end
            end
        end
    end

    // interrupt level from unmasked flags
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(interrupt_flags_r & interrupt_mask_r &
                     pattern_pkg::FLAG_FIELDS);
        end
    end

    // ------------------------------------------------------------
    // apb answer: registered in setup phase, zero-wait ready on access
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            pready  <= 1'b1;
            pslverr <= !known(paddr);
            unique case (paddr)
                pattern_pkg::ADDR_HIGH_COUNT:
                    prdata <= {24'h0, high_pattern_count_r};
                pattern_pkg::ADDR_LOW_COUNT:
                    prdata <= {24'h0, low_pattern_count_r};
                pattern_pkg::ADDR_CONTROL:
                    prdata <= {24'h0, pattern_detect_control_r};
                pattern_pkg::ADDR_SYSCTRL:
                    prdata <= {24'h0, system_control_bits_r};
                pattern_pkg::ADDR_FLAGS:
                    prdata <= {24'h0, interrupt_flags_r};
                pattern_pkg::ADDR_MASK:
                    prdata <= {24'h0, interrupt_mask_r};
                pattern_pkg::ADDR_STATUS:
                    prdata <= {22'h0, level_r, sat_seen_r, count_r};
                default:
                    prdata <= 32'h0000_0000;
            endcase
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_high_capture: assert property (@(posedge clk_sys) disable iff (!rstn)
        (enabled && fall) |=> high_pattern_count_r == $past(count_r))
        else $error("high count not captured on falling edge");
    a_low_capture: assert property (@(posedge clk_sys) disable iff (!rstn)
        (enabled && rise) |=> low_pattern_count_r == $past(count_r))
        else $error("low count not captured on rising edge");
    a_high_thresh: assert property (@(posedge clk_sys) disable iff (!rstn)
        (enabled && fall && count_r > high_pattern_count_r)
        |=> interrupt_flags_r[6])
        else $error("high flag missed on threshold");
    a_low_thresh: assert property (@(posedge clk_sys) disable iff (!rstn)
        (enabled && rise && count_r > low_pattern_count_r)
        |=> interrupt_flags_r[7])
        else $error("low flag missed on threshold");
    a_high_sat: assert property (@(posedge clk_sys) disable iff (!rstn)
        (enabled && tick && level_r && !new_level && at_max && !sat_seen_r)
        |=> interrupt_flags_r[6])
        else $error("high flag missed on saturation");
    a_low_sat: assert property (@(posedge clk_sys) disable iff (!rstn)
        (enabled && tick && !level_r && !new_level && at_max && !sat_seen_r)
        |=> interrupt_flags_r[7])
        else $error("low flag missed on saturation");
    a_irq_masked: assert property (@(posedge clk_sys) disable iff (!rstn)
        (interrupt_mask_r[7:6] == 2'b00) |=> !irq)
        else $error("interrupt raised while masked");
    a_count_sat: assert property (@(posedge clk_sys) disable iff (!rstn)
        (at_max && enabled && !new_level) |=> at_max)
        else $error("counter wrapped past maximum");
    a_idle_count: assert property (@(posedge clk_sys) disable iff (!rstn)
        !enabled |=> count_r == 8'h00)
        else $error("counter ran while disabled");
    a_ctrl_unused: assert property (@(posedge clk_sys) disable iff (!rstn)
        pattern_detect_control_r[3] == 1'b0 &&
        pattern_detect_control_r[7] == 1'b0)
        else $error("unused control bits set");

    c_fall_seen: cover property (@(posedge clk_sys) disable iff (!rstn)
        enabled && fall);
    c_rise_seen: cover property (@(posedge clk_sys) disable iff (!rstn)
        enabled && rise);
    c_irq_seen: cover property (@(posedge clk_sys) disable iff (!rstn)
        $rose(irq));
    c_sat_seen: cover property (@(posedge clk_sys) disable iff (!rstn)
        $rose(sat_seen_r));

endmodule

// ### pattern_pkg.sv
package pattern_pkg;

    // ------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_HIGH_COUNT = 8'h00;
    localparam logic [7:0] ADDR_LOW_COUNT  = 8'h04;
    localparam logic [7:0] ADDR_CONTROL    = 8'h08;
    localparam logic [7:0] ADDR_SYSCTRL    = 8'h0c;
    localparam logic [7:0] ADDR_FLAGS      = 8'h10;
    localparam logic [7:0] ADDR_MASK       = 8'h14;
    localparam logic [7:0] ADDR_STATUS     = 8'h18;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int         DEB_LSB       = 0;
    localparam int         RATE_LSB      = 4;
    localparam logic [7:0] CONTROL_MASK  = 8'h77;
    localparam logic [7:0] CONTROL_RESET = 8'h70;
    localparam logic [7:0] COUNT_RESET   = 8'h00;
    localparam int         ENABLE_BIT    = 2;
    localparam int         HIGH_FLAG_BIT = 6;
    localparam int         LOW_FLAG_BIT  = 7;
    localparam logic [7:0] FLAG_FIELDS   = 8'hc0;
    localparam logic [7:0] COUNT_MAX     = 8'hff;
    localparam logic [6:0] PRESCALE_ONE  = 7'h01;

endpackage

// ### sample_prescaler.sv
`timescale 1ns/1ps

// divides the oscillator clock by 2**rate, one-cycle tick per period
module sample_prescaler (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rstn,
    // control
    input  wire logic       run,
    input  wire logic [2:0] rate,
    // tick out
    output logic            tick
);

    logic [6:0] div_r;
    logic [6:0] limit;

    // terminal count for the selected power of two
    assign limit = 7'((pattern_pkg::PRESCALE_ONE << rate) - 7'h01);

    // free divider, held cleared while stopped
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            div_r <= 7'h00;
            tick  <= 1'b0;
        end else if (!run) begin
            div_r <= 7'h00;
            tick  <= 1'b0;
        end else if (div_r >= limit) begin
            div_r <= 7'h00;
            tick  <= 1'b1;
        end else begin
            div_r <= 7'(div_r + 7'h01);
            tick  <= 1'b0;
        end
    end

endmodule

// ### pin_source.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// external serial source feeding the pattern pin
// ----------------------------------------------------------------
module pin_source (
    // clock
    input  wire logic clk_sys,
    // level requested by the bench
    input  wire logic lvl_cmd,
    // serial line
    output logic      pattern_input_pin
);
    logic lvl_r = 1'b0;

    // input-only line, always driven, so it never floats
    always @(posedge clk_sys) begin
        lvl_r <= lvl_cmd;
    end
    assign pattern_input_pin = lvl_r;
endmodule

// ### tb.sv
`timescale 1ns/1ps

module tb;
    logic        clk_sys = 1'b0;
    logic        rstn    = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic        pin;
    logic        lvl_cmd = 1'b0;
    logic [31:0] q;
    logic        e;
    int          n_errors = 0;
    int          compares = 0;

    // 125 mhz system clock
    always #4 clk_sys = ~clk_sys;

    pulse_pattern_detector i_pulse_pattern_detector (
        .clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pattern_input_pin(pin),
        .irq(irq)
    );

    pin_source i_pin_source (
        .clk_sys(clk_sys), .lvl_cmd(lvl_cmd), .pattern_input_pin(pin)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic close_out();
        if (n_errors == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // range compare, exact when lo equals hi
    task automatic chk(input logic [31:0] got, input logic [31:0] lo,
                       input logic [31:0] hi);
        compares++;
        if ((^got === 1'bx) || got < lo || got > hi) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got, lo,
                     hi);
        end
    endtask

    // one apb transfer, waits for pready; the watchdog bounds the wait
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) begin
            @(posedge clk_sys);
        end
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] lo,
                      input logic [31:0] hi);
        apb(1'b0, a, 32'h0);
        chk(q, lo, hi);
    endtask

    // hold the line at a level for n cycles
    task automatic pulse(input logic lvl, input int n);
        lvl_cmd <= lvl;
        repeat (n) @(posedge clk_sys);
    endtask

    // ------------------------------------------------------------
    // watchdog and reset
    // ------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_errors++;
        close_out();
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk_sys);
        rstn <= 1'b1;
        rd(pattern_pkg::ADDR_CONTROL, 32'h70, 32'h70);
        rd(pattern_pkg::ADDR_HIGH_COUNT, 32'h0, 32'h0);
        apb(1'b0, 8'h1c, 32'h0);
        chk({31'h0, e}, 32'h1, 32'h1);
        chk(q, 32'h0, 32'h0);
        wr(pattern_pkg::ADDR_CONTROL, 32'hff);
        rd(pattern_pkg::ADDR_CONTROL, 32'h77, 32'h77);
        // disabled: counts are plain storage
        wr(pattern_pkg::ADDR_HIGH_COUNT, 32'h5a);
        pulse(1'b1, 20);
        pulse(1'b0, 20);
        rd(pattern_pkg::ADDR_HIGH_COUNT, 32'h5a, 32'h5a);
        rd(pattern_pkg::ADDR_FLAGS, 32'h0, 32'h0);
        // enabled, masked, low level held until saturation
        wr(pattern_pkg::ADDR_CONTROL, 32'h00);
        wr(pattern_pkg::ADDR_SYSCTRL, 32'h04);
        pulse(1'b0, 300);
        rd(pattern_pkg::ADDR_FLAGS, 32'h80, 32'h80);
        chk({31'h0, irq}, 32'h0, 32'h0);
        // thresholds then masks, as firmware must
        wr(pattern_pkg::ADDR_FLAGS, 32'hc0);
        wr(pattern_pkg::ADDR_HIGH_COUNT, 32'h14);
        wr(pattern_pkg::ADDR_LOW_COUNT, 32'h14);
        wr(pattern_pkg::ADDR_MASK, 32'hc0);
        pulse(1'b1, 40);
        pulse(1'b0, 8);
        rd(pattern_pkg::ADDR_LOW_COUNT, 32'hff, 32'hff);
        rd(pattern_pkg::ADDR_HIGH_COUNT, 32'h26, 32'h29);
        rd(pattern_pkg::ADDR_FLAGS, 32'hc0, 32'hc0);
        chk({31'h0, irq}, 32'h1, 32'h1);
        rd(pattern_pkg::ADDR_FLAGS, 32'hc0, 32'hc0);
        wr(pattern_pkg::ADDR_FLAGS, 32'hc0);
        repeat (2) @(posedge clk_sys);
        chk({31'h0, irq}, 32'h0, 32'h0);
        // masked: counts still load; equal width is not above threshold
        wr(pattern_pkg::ADDR_MASK, 32'h00);
        pulse(1'b1, 30);
        pulse(1'b0, 10);
        pulse(1'b1, 30);
        pulse(1'b0, 8);
        rd(pattern_pkg::ADDR_LOW_COUNT, 32'h09, 32'h0b);
        rd(pattern_pkg::ADDR_HIGH_COUNT, 32'h1d, 32'h1f);
        rd(pattern_pkg::ADDR_FLAGS, 32'h0, 32'h0);
        // debounce level 3 rejects a two-sample glitch
        wr(pattern_pkg::ADDR_CONTROL, 32'h03);
        pulse(1'b1, 2);
        pulse(1'b0, 3);
        pulse(1'b1, 30);
        pulse(1'b0, 12);
        rd(pattern_pkg::ADDR_LOW_COUNT, 32'h10, 32'hff);
        rd(pattern_pkg::ADDR_HIGH_COUNT, 32'h1d, 32'h1f);
        // sample rate divides the count by 2**field
        for (int r = 1; r < 4; r++) begin
            wr(pattern_pkg::ADDR_CONTROL, 32'(r << 4));
            pulse(1'b1, 64);
            pulse(1'b0, 24);
            rd(pattern_pkg::ADDR_HIGH_COUNT, 32'((64 >> r) - 1),
               32'((64 >> r) + 1));
        end
        // high level held until saturation, unmasked
        wr(pattern_pkg::ADDR_CONTROL, 32'h00);
        wr(pattern_pkg::ADDR_FLAGS, 32'hc0);
        wr(pattern_pkg::ADDR_MASK, 32'h40);
        pulse(1'b1, 300);
        apb(1'b0, pattern_pkg::ADDR_FLAGS, 32'h0);
        chk(q & 32'h40, 32'h40, 32'h40);
        chk({31'h0, irq}, 32'h1, 32'h1);
        // status: level high, saturation seen, count held at maximum
        rd(pattern_pkg::ADDR_STATUS, 32'h3ff, 32'h3ff);
        // disabled again: edges capture nothing, flag stays sticky
        wr(pattern_pkg::ADDR_SYSCTRL, 32'h00);
        pulse(1'b0, 20);
        rd(pattern_pkg::ADDR_HIGH_COUNT, 32'h07, 32'h09);
        chk({31'h0, irq}, 32'h1, 32'h1);
        // mid-run reset brings back reset values
        rstn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        chk({31'h0, irq}, 32'h0, 32'h0);
        rd(pattern_pkg::ADDR_CONTROL, 32'h70, 32'h70);
        rd(pattern_pkg::ADDR_FLAGS, 32'h0, 32'h0);
        rd(pattern_pkg::ADDR_HIGH_COUNT, 32'h0, 32'h0);
        close_out();
    end
endmodule
